// ==== rtl/wrc_pkg.sv ====
// constants, types and register map of the wake, reset and clock-failure controller
package wrc_pkg;
	// ****************************************
	// register map (byte offsets)
	// ****************************************
	localparam int ADDR_W = 10;
	localparam logic [9:0] OFS_MAIN_CLK_SEL = 10'h000;
	localparam logic [9:0] OFS_CPU_CLK_SEL = 10'h004;
	localparam logic [9:0] OFS_PB_A_CLK_SEL = 10'h00C;
	localparam logic [9:0] OFS_PB_B_CLK_SEL = 10'h010;
	localparam logic [9:0] OFS_PB_DIV_MASK = 10'h040;
	localparam logic [9:0] OFS_CLKFAIL_CTRL = 10'h054;
	localparam logic [9:0] OFS_UNLOCK = 10'h058;
	localparam logic [9:0] OFS_IRQ_ENABLE = 10'h0C0;
	localparam logic [9:0] OFS_IRQ_DISABLE = 10'h0C4;
	localparam logic [9:0] OFS_IRQ_MASK = 10'h0C8;
	localparam logic [9:0] OFS_IRQ_STATUS = 10'h0CC;
	localparam logic [9:0] OFS_IRQ_CLEAR = 10'h0D0;
	localparam logic [9:0] OFS_PM_STATUS = 10'h0D4;
	localparam logic [9:0] OFS_RESET_CAUSE = 10'h180;
	localparam logic [9:0] OFS_ASYNC_WAKE_EN = 10'h188;
	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int EV_W = 7;
	localparam int EV_CFD = 0;
	localparam int EV_CLK_SETTINGS_READY = 5;
	localparam int EV_AE = 6;
	localparam int RC_W = 9;
	localparam int RC_POR = 0;
	localparam int RC_EXT = 2;
	localparam int RC_WDT = 3;
	localparam int RC_SLEEP = 6;
	localparam int RC_OCD = 8;
	localparam logic [8:0] RC_RESET = 9'h001;
	localparam int ASYNC_WAKE_ENABLE_REG_WAKE_PIN = 0;
	localparam int CFD_EN_BIT = 0;
	localparam int SEL_W = 8;
	localparam int MCSEL_W = 3;
	localparam logic [2:0] MCSEL_SYSTEM_RC_OSC = 3'h0;
	localparam logic [7:0] UNLOCK_KEY = 8'hAA;
	localparam int KEY_LSB = 24;
	localparam logic [6:0] DIV_MASK_RESET = 7'h7F;
	// ****************************************
	// sleep modes
	// ****************************************
	localparam logic [2:0] MODE_PB_STOP = 3'h2;
	localparam logic [2:0] MODE_STOP = 3'h3;
	localparam logic [2:0] MODE_DEEPSTOP = 3'h4;
	localparam logic [2:0] MODE_SHUTDOWN = 3'h6;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {ST_RUN, ST_SHUTDOWN, ST_WAKE_REG} wrc_state_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [9:0] addr;
		logic [31:0] wdata;
	} wrc_bus_req_s;
	typedef struct packed {
		logic regulator_en;
		logic supply_mon_en;
		logic rc32k_en;
		logic sys_reset_n;
		logic por_reset;
	} wrc_pwr_s;
endpackage

// ==== rtl/wrc_top.sv ====
// wake, reset cause, clock-failure detector and interrupt logic of the power manager
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Function
// - in shutdown, a falling wake pad wakes the device
// - external reset low wakes from shutdown; reset held until it returns high
// - on wake, regulator on first, execution starts after core supply valid
// - wake from shutdown sets the sleep-wake flag in the reset cause register
// - wake pad already low at shutdown entry does not wake the device
// - wake source bit set and pad low: sleep aborts, reset cause unchanged
// - divided peripheral clocks are maskable and stop when peripheral clocks stop
// - power-on reset held while supply low, reasserted when it drops again
// - low external reset pin requests a reset
// - only power-on reset clears the configuration registers; interrupt mask and status keep their values
// - latest reset source kept in a read-only reset cause register
// - regulator supervisor trip counts as a power-on reset
// - failure when no main clock edge within one rc oscillator period
// - detector runs once software sets its enable bit
// - detector paused on rc source, clock gaps and stop or deepstop sleep
// - on failure switch to rc oscillator, show it in select, flag event
// - write to a locked register without unlock raises access error
// - clock ready event on rising edge of clock settings ready
// - status bit set on rising status edge, cleared by writing one to clear
// - enable write sets mask bits, disable write clears them, zeros ignored
// - masked sources ORed into one request held until status cleared
// - shutdown entry resets core and disables supply monitor and rc32k oscillator
module wrc_top #(
	parameter int DIV_N = 7,
	parameter int CLK_SETTINGS_READY_CYCLES = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire wrc_pkg::wrc_bus_req_s bus,
	output logic [31:0] rdata,
	// pins
	input wire logic wake_pad_n,
	input wire logic ext_reset_n,
	// other reset and wake sources
	input wire logic aot_wake,
	input wire logic wdt_reset,
	input wire logic ocd_reset,
	input wire logic core_supply_ok,
	input wire logic reg_supply_ok,
	input wire logic supervisor_trip,
	// sleep control from the cpu
	input wire logic sleep_req,
	input wire logic sleep_active,
	input wire logic [2:0] sleep_mode,
	output logic sleep_abort,
	// clocks
	input wire logic system_rc_osc_tick,
	input wire logic main_clk_edge,
	input wire logic main_clk_gap,
	output logic [2:0] main_clk_sel,
	output logic [DIV_N-1:0] pb_div_en,
	// power and status
	output wrc_pkg::wrc_pwr_s pwr,
	output logic cpu_start,
	output logic irq
);
	// ****************************************
	// functions
	// ****************************************
	function automatic logic is_protected(input logic [9:0] a);
		is_protected = (a == wrc_pkg::OFS_MAIN_CLK_SEL) || (a == wrc_pkg::OFS_CPU_CLK_SEL) ||
			(a == wrc_pkg::OFS_PB_A_CLK_SEL) || (a == wrc_pkg::OFS_PB_B_CLK_SEL) ||
			(a == wrc_pkg::OFS_PB_DIV_MASK) || (a == wrc_pkg::OFS_CLKFAIL_CTRL);
	endfunction

	function automatic logic [31:0] ev_word(input logic [wrc_pkg::EV_W-1:0] v);
		ev_word = {{(32 - wrc_pkg::EV_W){1'b0}}, v};
	endfunction

	// ****************************************
	// state
	// ****************************************
	wrc_pkg::wrc_state_e state, next_state;
	logic wake_prev;
	logic [2:0] mcsel;
	logic [wrc_pkg::SEL_W-1:0] cpu_sel, pba_sel, pbb_sel;
	logic [DIV_N-1:0] div_mask;
	logic cfd_en;
	logic async_wake_enable_reg_wake;
	logic unlocked;
	logic [9:0] unlock_ofs;
	logic clk_settings_ready;
	logic [7:0] clk_settings_ready_cnt;
	logic sr_cfd, sr_ae;
	logic [wrc_pkg::EV_W-1:0] sr_prev, irq_status_reg, irq_mask_reg;
	logic [wrc_pkg::RC_W-1:0] reset_cause_reg;
	logic edge_seen;
	logic cfd_fail;
	logic [DIV_N-1:0] presc;

	// ****************************************
	// bus decode
	// ****************************************
	wire logic wr_unlock = bus.wr && bus.addr == wrc_pkg::OFS_UNLOCK &&
		bus.wdata[wrc_pkg::KEY_LSB +: 8] == wrc_pkg::UNLOCK_KEY;
	wire logic wr_prot = bus.wr && is_protected(bus.addr);
	wire logic wr_ok = wr_prot && unlocked && unlock_ofs == bus.addr;
	wire logic access_err = wr_prot && !wr_ok;
	wire logic wr_mcsel = wr_ok && bus.addr == wrc_pkg::OFS_MAIN_CLK_SEL;
	wire logic wr_clksel = wr_ok && (bus.addr == wrc_pkg::OFS_CPU_CLK_SEL ||
		bus.addr == wrc_pkg::OFS_PB_A_CLK_SEL || bus.addr == wrc_pkg::OFS_PB_B_CLK_SEL);
	wire logic [wrc_pkg::EV_W-1:0] wv = bus.wdata[wrc_pkg::EV_W-1:0];
	wire logic [wrc_pkg::EV_W-1:0] ier_set = (bus.wr && bus.addr == wrc_pkg::OFS_IRQ_ENABLE) ? wv : '0;
	wire logic [wrc_pkg::EV_W-1:0] idr_clr = (bus.wr && bus.addr == wrc_pkg::OFS_IRQ_DISABLE) ? wv : '0;
	wire logic [wrc_pkg::EV_W-1:0] icr_clr = (bus.wr && bus.addr == wrc_pkg::OFS_IRQ_CLEAR) ? wv : '0;

	// ****************************************
	// sleep, wake and reset sources
	// ****************************************
	wire logic in_sd = state == wrc_pkg::ST_SHUTDOWN;
	wire logic sd_req = sleep_req && sleep_mode == wrc_pkg::MODE_SHUTDOWN && state == wrc_pkg::ST_RUN;
	wire logic abort = sd_req && async_wake_enable_reg_wake && !wake_pad_n;
	wire logic wake_fall = wake_prev && !wake_pad_n;
	// timer wake only arrives once software has armed crystal and timer
	wire logic wake_evt = in_sd && (wake_fall || !ext_reset_n || aot_wake);
	// monitor off in shutdown, otherwise the dying supply would read as a power-on
	wire logic por_cond = (pwr.supply_mon_en && (!reg_supply_ok || supervisor_trip)) ||
		(state == wrc_pkg::ST_RUN && !core_supply_ok);
	wire logic ext_rst = state == wrc_pkg::ST_RUN && !ext_reset_n;
	wire logic hold_rst = por_cond || ext_rst || wdt_reset || ocd_reset || next_state != wrc_pkg::ST_RUN;

	always_comb
	begin
		next_state = state;
		case (state)
			wrc_pkg::ST_RUN:
				if (sd_req && !abort)
					next_state = wrc_pkg::ST_SHUTDOWN;
			wrc_pkg::ST_SHUTDOWN:
				if (wake_evt)
					next_state = wrc_pkg::ST_WAKE_REG;
			wrc_pkg::ST_WAKE_REG:
				if (core_supply_ok && ext_reset_n)
					next_state = wrc_pkg::ST_RUN;
			default:
				next_state = wrc_pkg::ST_RUN;
		endcase
	end

	wire logic wake_done = state == wrc_pkg::ST_WAKE_REG && next_state == wrc_pkg::ST_RUN;
	wire logic [wrc_pkg::RC_W-1:0] next_reset_cause_reg =
		por_cond ? wrc_pkg::RC_W'(1 << wrc_pkg::RC_POR) :
		ext_rst ? wrc_pkg::RC_W'(1 << wrc_pkg::RC_EXT) :
		wdt_reset ? wrc_pkg::RC_W'(1 << wrc_pkg::RC_WDT) :
		ocd_reset ? wrc_pkg::RC_W'(1 << wrc_pkg::RC_OCD) :
		wake_done ? wrc_pkg::RC_W'(1 << wrc_pkg::RC_SLEEP) : reset_cause_reg;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= wrc_pkg::ST_RUN;
			wake_prev <= 1'b1;
			reset_cause_reg <= wrc_pkg::RC_RESET;
			pwr <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
			cpu_start <= 1'b0;
			sleep_abort <= 1'b0;
		end
		else
		begin
			state <= next_state;
			wake_prev <= wake_pad_n;
			reset_cause_reg <= next_reset_cause_reg;
			pwr.regulator_en <= next_state != wrc_pkg::ST_SHUTDOWN;
			pwr.supply_mon_en <= next_state == wrc_pkg::ST_RUN;
			pwr.rc32k_en <= next_state == wrc_pkg::ST_RUN;
			pwr.sys_reset_n <= !hold_rst;
			pwr.por_reset <= por_cond;
			cpu_start <= wake_done;
			sleep_abort <= abort;
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	// only a power-on clears these; other resets leave software setup intact
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mcsel <= wrc_pkg::MCSEL_SYSTEM_RC_OSC;
			cpu_sel <= '0;
			pba_sel <= '0;
			pbb_sel <= '0;
			div_mask <= DIV_N'(wrc_pkg::DIV_MASK_RESET);
			cfd_en <= 1'b0;
			async_wake_enable_reg_wake <= 1'b0;
			unlocked <= 1'b0;
			unlock_ofs <= '0;
		end
		else if (por_cond)
		begin
			mcsel <= wrc_pkg::MCSEL_SYSTEM_RC_OSC;
			cpu_sel <= '0;
			pba_sel <= '0;
			pbb_sel <= '0;
			div_mask <= DIV_N'(wrc_pkg::DIV_MASK_RESET);
			cfd_en <= 1'b0;
			async_wake_enable_reg_wake <= 1'b0;
			unlocked <= 1'b0;
		end
		else
		begin
			if (cfd_fail)
				mcsel <= wrc_pkg::MCSEL_SYSTEM_RC_OSC;
			else if (wr_mcsel)
				mcsel <= bus.wdata[wrc_pkg::MCSEL_W-1:0];
			if (wr_ok && bus.addr == wrc_pkg::OFS_CPU_CLK_SEL)
				cpu_sel <= bus.wdata[wrc_pkg::SEL_W-1:0];
			if (wr_ok && bus.addr == wrc_pkg::OFS_PB_A_CLK_SEL)
				pba_sel <= bus.wdata[wrc_pkg::SEL_W-1:0];
			if (wr_ok && bus.addr == wrc_pkg::OFS_PB_B_CLK_SEL)
				pbb_sel <= bus.wdata[wrc_pkg::SEL_W-1:0];
			if (wr_ok && bus.addr == wrc_pkg::OFS_PB_DIV_MASK)
				div_mask <= bus.wdata[DIV_N-1:0];
			if (wr_ok && bus.addr == wrc_pkg::OFS_CLKFAIL_CTRL)
				cfd_en <= bus.wdata[wrc_pkg::CFD_EN_BIT];
			if (bus.wr && bus.addr == wrc_pkg::OFS_ASYNC_WAKE_EN)
				async_wake_enable_reg_wake <= bus.wdata[wrc_pkg::ASYNC_WAKE_ENABLE_REG_WAKE_PIN];
			// an unlock covers exactly one following write
			if (wr_unlock)
				unlocked <= 1'b1;
			else if (bus.wr)
				unlocked <= 1'b0;
			if (wr_unlock)
				unlock_ofs <= bus.wdata[wrc_pkg::ADDR_W-1:0];
		end
	end

	// ****************************************
	// clock settings ready and divided clocks
	// ****************************************
	wire logic pb_stopped = (sleep_active && sleep_mode >= wrc_pkg::MODE_PB_STOP) || state != wrc_pkg::ST_RUN;
	logic [DIV_N-1:0] div_hit;
	for (genvar i = 0; i < DIV_N; i++)
	begin : g_div
		assign div_hit[i] = &presc[i:0];
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			clk_settings_ready <= 1'b1;
			clk_settings_ready_cnt <= '0;
			presc <= '0;
			pb_div_en <= '0;
		end
		else
		begin
			if (wr_clksel)
			begin
				clk_settings_ready <= 1'b0;
				clk_settings_ready_cnt <= 8'(CLK_SETTINGS_READY_CYCLES);
			end
			else if (clk_settings_ready_cnt != '0)
			begin
				clk_settings_ready_cnt <= clk_settings_ready_cnt - 8'h01;
				clk_settings_ready <= clk_settings_ready_cnt == 8'h01;
			end
			presc <= presc + DIV_N'(1);
			pb_div_en <= div_hit & div_mask & {DIV_N{!pb_stopped}};
		end
	end

	// ****************************************
	// clock failure detector
	// ****************************************
	wire logic rc_sleep = sleep_active && (sleep_mode == wrc_pkg::MODE_STOP || sleep_mode == wrc_pkg::MODE_DEEPSTOP);
	wire logic cfd_mon = cfd_en && mcsel != wrc_pkg::MCSEL_SYSTEM_RC_OSC && !main_clk_gap && !rc_sleep &&
		state == wrc_pkg::ST_RUN;
	assign cfd_fail = cfd_mon && system_rc_osc_tick && !edge_seen && !main_clk_edge;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			edge_seen <= 1'b1;
			sr_cfd <= 1'b0;
			sr_ae <= 1'b0;
			main_clk_sel <= wrc_pkg::MCSEL_SYSTEM_RC_OSC;
		end
		else
		begin
			// a fresh window after any pause avoids a false trip
			if (!cfd_mon || main_clk_edge)
				edge_seen <= 1'b1;
			else if (system_rc_osc_tick)
				edge_seen <= 1'b0;
			if (cfd_fail)
				sr_cfd <= 1'b1;
			else if (wr_mcsel || por_cond)
				sr_cfd <= 1'b0;
			sr_ae <= access_err;
			main_clk_sel <= cfd_fail ? wrc_pkg::MCSEL_SYSTEM_RC_OSC : (wr_mcsel && !por_cond) ?
				bus.wdata[wrc_pkg::MCSEL_W-1:0] : por_cond ? wrc_pkg::MCSEL_SYSTEM_RC_OSC : mcsel;
		end
	end

	// ****************************************
	// interrupt status and mask
	// ****************************************
	logic [wrc_pkg::EV_W-1:0] sr_now;
	always_comb
	begin
		sr_now = '0;
		sr_now[wrc_pkg::EV_CFD] = sr_cfd;
		sr_now[wrc_pkg::EV_CLK_SETTINGS_READY] = clk_settings_ready;
		sr_now[wrc_pkg::EV_AE] = sr_ae;
	end
	wire logic [wrc_pkg::EV_W-1:0] sr_rise = sr_now & ~sr_prev;
	wire logic [wrc_pkg::EV_W-1:0] next_isr = (irq_status_reg & ~icr_clr) | sr_rise;
	wire logic [wrc_pkg::EV_W-1:0] next_imr = (irq_mask_reg | ier_set) & ~idr_clr;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sr_prev <= '0;
			sr_prev[wrc_pkg::EV_CLK_SETTINGS_READY] <= 1'b1;
			irq_status_reg <= '0;
			irq_mask_reg <= '0;
			irq <= 1'b0;
		end
		else
		begin
			sr_prev <= sr_now;
			irq_status_reg <= next_isr;
			irq_mask_reg <= next_imr;
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// ****************************************
	// register read
	// ****************************************
	wire logic [31:0] rd_mux =
		bus.addr == wrc_pkg::OFS_MAIN_CLK_SEL ? {29'h0, mcsel} :
		bus.addr == wrc_pkg::OFS_CPU_CLK_SEL ? {24'h0, cpu_sel} :
		bus.addr == wrc_pkg::OFS_PB_A_CLK_SEL ? {24'h0, pba_sel} :
		bus.addr == wrc_pkg::OFS_PB_B_CLK_SEL ? {24'h0, pbb_sel} :
		bus.addr == wrc_pkg::OFS_PB_DIV_MASK ? {{(32 - DIV_N){1'b0}}, div_mask} :
		bus.addr == wrc_pkg::OFS_CLKFAIL_CTRL ? {31'h0, cfd_en} :
		bus.addr == wrc_pkg::OFS_IRQ_MASK ? ev_word(irq_mask_reg) :
		bus.addr == wrc_pkg::OFS_IRQ_STATUS ? ev_word(irq_status_reg) :
		bus.addr == wrc_pkg::OFS_PM_STATUS ? ev_word(sr_now) :
		bus.addr == wrc_pkg::OFS_RESET_CAUSE ? {23'h0, reset_cause_reg} :
		bus.addr == wrc_pkg::OFS_ASYNC_WAKE_EN ? {31'h0, async_wake_enable_reg_wake} : 32'h0;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rdata <= '0;
		else
			rdata <= bus.rd ? rd_mux : 32'h0;
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_enter;
		sd_req && !abort && !por_cond;
	endsequence
	sequence s_wake;
		wake_evt ##1 state == wrc_pkg::ST_WAKE_REG;
	endsequence

	sleep_abort_a: assert property (abort |=> sleep_abort && state == wrc_pkg::ST_RUN && $stable(reset_cause_reg))
		else $error("sleep abort wrong");
	shutdown_entry_a: assert property (s_enter |=> in_sd && !pwr.supply_mon_en && !pwr.rc32k_en && !pwr.sys_reset_n)
		else $error("shutdown entry wrong");
	regulator_wake_a: assert property (s_wake |-> pwr.regulator_en && !cpu_start)
		else $error("regulator not on at wake");
	hold_reset_a: assert property (state == wrc_pkg::ST_WAKE_REG && !ext_reset_n |=> state == wrc_pkg::ST_WAKE_REG
		&& !pwr.sys_reset_n)
		else $error("left reset early");
	sleep_flag_a: assert property (cpu_start |-> reset_cause_reg[wrc_pkg::RC_SLEEP] && pwr.sys_reset_n)
		else $error("sleep flag missing");
	level_ignored_a: assert property (in_sd && !wake_prev && !wake_pad_n && ext_reset_n && !aot_wake
		|=> in_sd)
		else $error("low level woke device");
	clkfail_switch_a: assert property (cfd_fail |=> mcsel == wrc_pkg::MCSEL_SYSTEM_RC_OSC && sr_cfd ##1 irq_status_reg[wrc_pkg::EV_CFD])
		else $error("clock failure not handled");
	access_err_a: assert property (access_err |=> sr_ae ##1 irq_status_reg[wrc_pkg::EV_AE])
		else $error("access error missed");
	status_hold_a: assert property (irq_status_reg[wrc_pkg::EV_CLK_SETTINGS_READY] && !icr_clr[wrc_pkg::EV_CLK_SETTINGS_READY] |=> irq_status_reg[wrc_pkg::EV_CLK_SETTINGS_READY])
		else $error("status lost");
	set_wins_a: assert property (sr_rise[wrc_pkg::EV_CLK_SETTINGS_READY] && icr_clr[wrc_pkg::EV_CLK_SETTINGS_READY] |=> irq_status_reg[wrc_pkg::EV_CLK_SETTINGS_READY])
		else $error("clear beat set");
	irq_out_a: assert property (|(irq_status_reg & irq_mask_reg) |=> irq)
		else $error("request not raised");
	por_out_a: assert property (por_cond |=> pwr.por_reset && !pwr.sys_reset_n && reset_cause_reg[wrc_pkg::RC_POR])
		else $error("power-on reset missing");
endmodule // wrc_top

// ==== tb/wrc_far_model.sv ====
// far-side model: wake pad, reset pin, always-on timer, supplies and clock ticks
`timescale 1ns/1ps
module wrc_far_model #(
	parameter int RC_PER = 16,
	parameter int SUP_DLY = 3
) (
	// clock
	input wire logic clk,
	// commands from the bench
	input wire logic pad_low,
	input wire logic rst_low,
	input wire logic timer_fire,
	input wire logic clk_dead,
	input wire logic supply_drop,
	input wire wrc_pkg::wrc_pwr_s pwr,
	// pins and sources
	output logic wake_pad_n = 1'b1,
	output logic ext_reset_n = 1'b1,
	output logic aot_wake = 1'b0,
	output logic core_supply_ok,
	output logic reg_supply_ok = 1'b1,
	output logic system_rc_osc_tick = 1'b0,
	output logic main_clk_edge = 1'b0
);
	logic [SUP_DLY-1:0] sup_sr = '1;
	int rc_cnt = 0;
	logic half = 1'b0;
	always @(posedge clk)
	begin
		wake_pad_n <= !pad_low;
		ext_reset_n <= !rst_low; // pull-up: high unless pulled
		aot_wake <= timer_fire; // fired only once the timer counts as set up
		sup_sr <= {sup_sr[SUP_DLY-2:0], pwr.regulator_en};
		reg_supply_ok <= !supply_drop;
		rc_cnt <= (rc_cnt == RC_PER - 1) ? 0 : rc_cnt + 1;
		system_rc_osc_tick <= (rc_cnt == RC_PER - 1);
		half <= !half;
		main_clk_edge <= half && !clk_dead;
	end
	// supply valid only some cycles after the regulator comes back
	assign core_supply_ok = &sup_sr;
endmodule // wrc_far_model

// ==== tb/wrc_top_tb.sv ====
// self-checking bench of the wake, reset and clock-failure controller
`timescale 1ns/1ps
module wrc_top_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	wrc_pkg::wrc_bus_req_s bus = '0;
	logic [31:0] rdata;
	logic wake_pad_n, ext_reset_n, aot_wake, core_supply_ok, reg_supply_ok, system_rc_osc_tick, main_clk_edge;
	logic wdt_reset = 1'b0, supervisor_trip = 1'b0, sleep_req = 1'b0, sleep_active = 1'b0;
	logic ocd_reset = 1'b0, main_clk_gap = 1'b0;
	logic [2:0] sleep_mode = 3'h0;
	logic sleep_abort, cpu_start, irq;
	logic [2:0] main_clk_sel;
	logic [6:0] pb_div_en;
	wrc_pkg::wrc_pwr_s pwr;
	logic pad_low = 1'b0, rst_low = 1'b0, timer_fire = 1'b0, clk_dead = 1'b0, supply_drop = 1'b0;
	logic [31:0] rd_val;
	logic [31:0] keep;
	int n;
	int miscompares = 0;
	int compares = 0;
	always #4 clk = !clk;
	wrc_top #(.DIV_N(7), .CLK_SETTINGS_READY_CYCLES(4)) u_wrc_top (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
		.wake_pad_n(wake_pad_n), .ext_reset_n(ext_reset_n), .aot_wake(aot_wake), .wdt_reset(wdt_reset),
		.ocd_reset(ocd_reset), .core_supply_ok(core_supply_ok), .reg_supply_ok(reg_supply_ok),
		.supervisor_trip(supervisor_trip), .sleep_req(sleep_req), .sleep_active(sleep_active),
		.sleep_mode(sleep_mode), .sleep_abort(sleep_abort), .system_rc_osc_tick(system_rc_osc_tick), .main_clk_edge(main_clk_edge),
		.main_clk_gap(main_clk_gap), .main_clk_sel(main_clk_sel), .pb_div_en(pb_div_en), .pwr(pwr),
		.cpu_start(cpu_start), .irq(irq));
	wrc_far_model u_wrc_far_model (.clk(clk), .pad_low(pad_low), .rst_low(rst_low), .timer_fire(timer_fire),
		.clk_dead(clk_dead), .supply_drop(supply_drop), .pwr(pwr), .wake_pad_n(wake_pad_n),
		.ext_reset_n(ext_reset_n), .aot_wake(aot_wake), .core_supply_ok(core_supply_ok),
		.reg_supply_ok(reg_supply_ok), .system_rc_osc_tick(system_rc_osc_tick), .main_clk_edge(main_clk_edge));
	// ****************************************
	// bus cycles and helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [9:0] a);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		bus <= '0;
		#1;
		rd_val = rdata;
	endtask
	// unlock first: the key only covers the very next write
	task automatic uwr(input logic [9:0] a, input logic [31:0] d);
		wr(wrc_pkg::OFS_UNLOCK, {wrc_pkg::UNLOCK_KEY, 14'h0, a});
		wr(a, d);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic pulses(input int b);
		n = 0;
		repeat (16)
		begin
			cyc(1);
			if (pb_div_en[b] === 1'b1)
				n++;
		end
	endtask
	task automatic shutdown_req();
		@(posedge clk);
		sleep_mode <= wrc_pkg::MODE_SHUTDOWN;
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		#1;
	endtask
	task automatic wait_start();
		for (int i = 0; i < 100 && cpu_start !== 1'b1; i++)
			cyc(1);
		chk({31'h0, cpu_start}, 32'h1, "cpu start");
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset_values();
		rd(wrc_pkg::OFS_PB_DIV_MASK);
		chk(rd_val, 32'h0000007F, "div mask");
		rd(wrc_pkg::OFS_PM_STATUS);
		chk(rd_val, 32'h00000020, "status");
		rd(wrc_pkg::OFS_RESET_CAUSE);
		chk(rd_val, 32'h00000001, "cause");
		wr(wrc_pkg::OFS_RESET_CAUSE, 32'h0000FFFF);
		rd(wrc_pkg::OFS_RESET_CAUSE);
		chk(rd_val, 32'h00000001, "cause ro");
		rd(10'h100);
		chk(rd_val, 32'h0, "unmapped");
	endtask
	task automatic t_div();
		for (int b = 0; b < 4; b++)
		begin
			pulses(b);
			chk(n, 16 >> (b + 1), "div rate");
		end
		@(posedge clk);
		sleep_mode <= wrc_pkg::MODE_PB_STOP;
		sleep_active <= 1'b1;
		cyc(2);
		pulses(0);
		chk(n, 0, "div in sleep");
		@(posedge clk);
		sleep_active <= 1'b0;
		uwr(wrc_pkg::OFS_PB_DIV_MASK, 32'h7E);
		pulses(0);
		chk(n, 0, "div masked");
		pulses(1);
		chk(n, 4, "div unmasked");
	endtask
	task automatic t_irq();
		wr(wrc_pkg::OFS_IRQ_CLEAR, 32'h7F);
		wr(wrc_pkg::OFS_IRQ_ENABLE, 32'h40);
		wr(wrc_pkg::OFS_IRQ_ENABLE, 32'h0);
		rd(wrc_pkg::OFS_IRQ_MASK);
		chk(rd_val, 32'h40, "mask set");
		wr(wrc_pkg::OFS_CPU_CLK_SEL, 32'h5);
		cyc(4);
		rd(wrc_pkg::OFS_IRQ_STATUS);
		chk(rd_val, 32'h40, "access error");
		chk({31'h0, irq}, 32'h1, "irq on");
		rd(wrc_pkg::OFS_CPU_CLK_SEL);
		chk(rd_val, 32'h0, "locked write");
		wr(wrc_pkg::OFS_IRQ_CLEAR, 32'h40);
		cyc(2);
		chk({31'h0, irq}, 32'h0, "irq off");
		wr(wrc_pkg::OFS_IRQ_DISABLE, 32'h40);
		rd(wrc_pkg::OFS_IRQ_MASK);
		chk(rd_val, 32'h0, "mask clear");
		wr(wrc_pkg::OFS_CPU_CLK_SEL, 32'h5);
		cyc(4);
		rd(wrc_pkg::OFS_IRQ_STATUS);
		chk(rd_val, 32'h40, "status masked");
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr(wrc_pkg::OFS_IRQ_CLEAR, 32'h40);
		uwr(wrc_pkg::OFS_CPU_CLK_SEL, 32'h81);
		// clear taken on the very edge that takes the ready rise, five cycles after the select write
		repeat (3) @(posedge clk);
		wr(wrc_pkg::OFS_IRQ_CLEAR, 32'h20);
		cyc(4);
		rd(wrc_pkg::OFS_IRQ_STATUS);
		chk(rd_val, 32'h20, "clock ready");
		rd(wrc_pkg::OFS_CPU_CLK_SEL);
		chk(rd_val, 32'h81, "cpu sel");
		wr(wrc_pkg::OFS_IRQ_CLEAR, 32'h20);
	endtask
	task automatic t_clkfail();
		uwr(wrc_pkg::OFS_CLKFAIL_CTRL, 32'h1);
		uwr(wrc_pkg::OFS_MAIN_CLK_SEL, 32'h1);
		wr(wrc_pkg::OFS_IRQ_ENABLE, 32'h1);
		sleep_mode <= wrc_pkg::MODE_STOP;
		sleep_active <= 1'b1;
		clk_dead <= 1'b1;
		cyc(40);
		chk({29'h0, main_clk_sel}, 32'h1, "paused in stop");
		@(posedge clk);
		sleep_mode <= wrc_pkg::MODE_DEEPSTOP;
		cyc(40);
		chk({29'h0, main_clk_sel}, 32'h1, "paused in deepstop");
		@(posedge clk);
		sleep_active <= 1'b0;
		main_clk_gap <= 1'b1;
		cyc(40);
		chk({29'h0, main_clk_sel}, 32'h1, "paused in gap");
		@(posedge clk);
		main_clk_gap <= 1'b0;
		for (int i = 0; i < 64 && main_clk_sel !== 3'h0; i++)
			cyc(1);
		chk({29'h0, main_clk_sel}, 32'h0, "fallback");
		rd(wrc_pkg::OFS_PM_STATUS);
		chk(rd_val & 32'h1, 32'h1, "fail status");
		cyc(3);
		chk({31'h0, irq}, 32'h1, "fail irq");
		@(posedge clk);
		clk_dead <= 1'b0;
		wr(wrc_pkg::OFS_IRQ_CLEAR, 32'h1);
		wr(wrc_pkg::OFS_IRQ_DISABLE, 32'h1);
	endtask
	task automatic t_wake(input int src);
		shutdown_req();
		chk({28'h0, pwr.regulator_en, pwr.supply_mon_en, pwr.rc32k_en, pwr.sys_reset_n}, 32'h0, "off");
		cyc(8);
		@(posedge clk);
		pad_low <= (src == 0);
		timer_fire <= (src == 1);
		rst_low <= (src == 2);
		if (src == 2)
		begin
			cyc(20);
			chk({31'h0, cpu_start | pwr.sys_reset_n}, 32'h0, "held");
			@(posedge clk);
			rst_low <= 1'b0;
		end
		wait_start();
		chk({31'h0, core_supply_ok & pwr.regulator_en}, 32'h1, "supply first");
		@(posedge clk);
		pad_low <= 1'b0;
		timer_fire <= 1'b0;
		rd(wrc_pkg::OFS_RESET_CAUSE);
		chk(rd_val & 32'h40, 32'h40, "sleep flag");
	endtask
	task automatic t_pad_early();
		@(posedge clk);
		pad_low <= 1'b1;
		shutdown_req();
		cyc(30);
		chk({31'h0, pwr.regulator_en}, 32'h0, "early low");
		@(posedge clk);
		pad_low <= 1'b0;
		cyc(4);
		@(posedge clk);
		pad_low <= 1'b1;
		wait_start();
		@(posedge clk);
		pad_low <= 1'b0;
		wr(wrc_pkg::OFS_ASYNC_WAKE_EN, 32'h1);
		rd(wrc_pkg::OFS_RESET_CAUSE);
		keep = rd_val;
		@(posedge clk);
		pad_low <= 1'b1;
		cyc(3);
		shutdown_req();
		for (int i = 0; i < 3 && sleep_abort !== 1'b1; i++)
			cyc(1);
		chk({31'h0, sleep_abort}, 32'h1, "abort");
		chk({31'h0, pwr.regulator_en}, 32'h1, "still on");
		@(posedge clk);
		pad_low <= 1'b0;
		rd(wrc_pkg::OFS_RESET_CAUSE);
		chk(rd_val, keep, "cause kept");
	endtask
	task automatic t_resets();
		@(posedge clk);
		wdt_reset <= 1'b1;
		@(posedge clk);
		wdt_reset <= 1'b0;
		cyc(6);
		rd(wrc_pkg::OFS_RESET_CAUSE);
		chk(rd_val, 32'h1 << wrc_pkg::RC_WDT, "wdt cause");
		@(posedge clk);
		ocd_reset <= 1'b1;
		@(posedge clk);
		ocd_reset <= 1'b0;
		cyc(6);
		rd(wrc_pkg::OFS_RESET_CAUSE);
		chk(rd_val, 32'h1 << wrc_pkg::RC_OCD, "debug cause");
		@(posedge clk);
		rst_low <= 1'b1;
		cyc(4);
		chk({31'h0, pwr.sys_reset_n}, 32'h0, "pin reset");
		@(posedge clk);
		rst_low <= 1'b0;
		cyc(6);
		rd(wrc_pkg::OFS_RESET_CAUSE);
		chk(rd_val, 32'h1 << wrc_pkg::RC_EXT, "pin cause");
		@(posedge clk);
		supervisor_trip <= 1'b1;
		@(posedge clk);
		supervisor_trip <= 1'b0;
		cyc(6);
		rd(wrc_pkg::OFS_RESET_CAUSE);
		chk(rd_val, 32'h1, "trip cause");
		uwr(wrc_pkg::OFS_PB_DIV_MASK, 32'h1);
		@(posedge clk);
		supply_drop <= 1'b1;
		cyc(4);
		chk({30'h0, pwr.por_reset, pwr.sys_reset_n}, 32'h2, "por held");
		@(posedge clk);
		supply_drop <= 1'b0;
		cyc(6);
		chk({31'h0, pwr.sys_reset_n}, 32'h1, "por gone");
		rd(wrc_pkg::OFS_PB_DIV_MASK);
		chk(rd_val, 32'h7F, "por clears");
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		cyc(2);
		t_reset_values();
		t_div();
		t_irq();
		t_clkfail();
		for (int s = 0; s < 3; s++)
			t_wake(s);
		t_pad_early();
		t_resets();
		give_verdict();
	end
	// runs need under a thousand cycles; a hang is cut at 20000 cycles, well beyond that
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
endmodule // wrc_top_tb
